// ---- bench/front_end_model.sv ----
// Model of the transmit attenuator and the observation power path.
`timescale 1ns/10ps
module front_end_model import loop_gain_pkg::*; (
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic [ATTEN_W-1:0] atten,
   input  wire logic [PWR_W-1:0]   tx_lvl,
   input  wire logic [PWR_W-1:0]   path_gain,
   input  wire logic               snr_good,
   output sample_s                 sample,
   output logic                    obs_snr_ok
);
   logic ph_q;
   // Samples are valid every other cycle; idle cycles carry junk.
   always_ff @(posedge sys_clk) begin
      ph_q <= nrst ? ~ph_q : 1'b0;
      sample.valid <= nrst & ph_q;
      sample.tx_pwr <= ph_q ? tx_lvl : ~tx_lvl;
      sample.obs_pwr <= tx_lvl + path_gain - PWR_W'(atten);
      obs_snr_ok <= snr_good;
   end
endmodule

// ---- bench/lgac_chk.sv ----
// Checker of the attenuation update behaviour at the top ports.
`timescale 1ns/10ps
module lgac_chk import loop_gain_pkg::*; #(
   parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
   input wire logic              sys_clk,
   input wire logic              nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire sample_s           sample,
   input wire logic              obs_snr_ok,
   input wire logic [ATTEN_W-1:0] applied_atten_index,
   input wire logic              atten_update,
   input wire logic              irq
);
   logic [ATTEN_W-1:0] lo_q;
   logic [ATTEN_W-1:0] hi_q;
   logic [STEP_W-1:0]  stp_q;
   logic [EV_W-1:0]    msk_q;
   logic               act_q;
   // Shadow copies of the limits, tracked from register writes.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         lo_q <= RST_LOWER;
         hi_q <= RST_UPPER;
         stp_q <= RST_STEP;
         msk_q <= '0;
         act_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == OFS_LOWER) lo_q <= reg_wdata[ATTEN_W-1:0];
         if (reg_addr == OFS_UPPER) hi_q <= reg_wdata[ATTEN_W-1:0];
         if (reg_addr == OFS_STEP) stp_q <= reg_wdata[STEP_W-1:0];
         if (reg_addr == OFS_MASK) msk_q <= reg_wdata[EV_W-1:0];
         if (reg_addr == OFS_CTRL) act_q <= reg_wdata[CTRL_ACTIVE_BIT];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   a_change_needs_upd: assert property (
      applied_atten_index != $past(applied_atten_index) |-> atten_update)
      else $error("attenuation moved without an update pulse");
   a_step_bound: assert property (
      atten_update |-> (applied_atten_index > $past(applied_atten_index) ?
      applied_atten_index - $past(applied_atten_index) :
      $past(applied_atten_index) - applied_atten_index) <= stp_q)
      else $error("attenuation step too large");
   a_lower_bound: assert property (
      atten_update |-> applied_atten_index >= lo_q)
      else $error("attenuation below lower bound");
   a_upper_bound: assert property (
      atten_update |-> applied_atten_index <= hi_q)
      else $error("attenuation above upper bound");
   a_passive_hold: assert property (
      applied_atten_index != $past(applied_atten_index) |-> act_q)
      else $error("attenuation moved in passive mode");
   a_update_pulse: assert property (
      atten_update |=> !atten_update [*8])
      else $error("update pulse too long");
   a_rdata_idle: assert property (reg_rdata != '0 |-> $past(reg_rd))
      else $error("read data outside read cycle");
   a_irq_masked: assert property (irq |-> msk_q != '0)
      else $error("interrupt with all events masked");
endmodule

// ---- bench/loop_gain_attenuation_control_tb_top.sv ----
// Self-checking bench of the loop gain attenuation control.
`timescale 1ns/10ps
module loop_gain_attenuation_control_tb_top import loop_gain_pkg::*;;
   localparam int PER = 3000;
   logic sys_clk, nrst, reg_wr, reg_rd, obs_snr_ok, atten_update, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [ATTEN_W-1:0] applied_atten_index;
   logic [PWR_W-1:0] tx_lvl;
   logic snr_good;
   sample_s sample;
   int fails, checks_done, seed, cyc, n, a_exp, lo, hi, stp, tgt, pg;
   loop_gain_attenuation_control #(.UPDATE_CYCLES_P(PER)) dut (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample(sample), .obs_snr_ok(obs_snr_ok),
      .applied_atten_index(applied_atten_index),
      .atten_update(atten_update), .irq(irq));
   front_end_model fe (.sys_clk(sys_clk), .nrst(nrst),
      .atten(applied_atten_index), .tx_lvl(tx_lvl),
      .path_gain(PWR_W'(pg)), .snr_good(snr_good), .sample(sample),
      .obs_snr_ok(obs_snr_ok));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] s, e, input string nm);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %0d seen %0d", nm, e, s);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input int v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= DATA_W'(v);
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // ****************************************
   // Reference model of one active update
   // ****************************************
   task automatic upd(input string nm);
      int e;
      n = 0;
      do begin
         @(posedge sys_clk);
         tx_lvl <= PWR_W'(-200 - ($random(seed) & 63));
         #1 n++;
      end while (atten_update !== 1'b1 && n < 4000);
      e = tgt - (pg - a_exp);
      if (e > stp) e = stp;
      if (e < -stp) e = -stp;
      a_exp = a_exp - e;
      if (a_exp < lo) a_exp = lo;
      else if (a_exp > hi) a_exp = hi;
      chk(DATA_W'(applied_atten_index), DATA_W'(a_exp), nm);
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      seed = 54;
      tx_lvl = 16'hFF38;
      snr_good = 1'b1;
      pg = 56;
      {a_exp, lo, tgt} = '0;
      hi = 839;
      stp = 20;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(OFS_STEP);
      chk(d, 32'h0000_0014, "step");
      rd(OFS_UPPER);
      chk(d, 32'h0000_0347, "upper");
      rd(8'h40);
      chk(d, 32'h0000_0000, "unmapped");
      $display("test reset done");
      wr(OFS_DURATION, 10);
      wr(OFS_MASK, 1);
      wr(OFS_CTRL, 3);
      for (int i = 0; i < 3; i++) begin
         upd("converge");
         if (i > 0) chk(DATA_W'(n), DATA_W'(PER), "period");
      end
      chk({31'b0, irq}, 1, "irq_set");
      wr(OFS_STATUS, 1);
      @(posedge sys_clk);
      #1 chk({31'b0, irq}, 0, "irq_clr");
      $display("test converge done");
      wr(OFS_UPPER, 60);
      hi = 60;
      pg = 200;
      upd("upper");
      upd("upper_hold");
      wr(OFS_LOWER, 50);
      wr(OFS_TARGET, 500);
      lo = 50;
      tgt = 500;
      upd("lower");
      $display("test bounds done");
      wr(OFS_MASK, 0);
      wr(OFS_STATUS, 7);
      wr(OFS_CTRL, 2);
      repeat (PER + 300) @(posedge sys_clk);
      rd(OFS_STATUS);
      chk(d, 32'h0000_0001, "passive_status");
      chk({31'b0, irq}, 0, "irq_masked");
      rd(OFS_ATTEN);
      chk(d, DATA_W'(a_exp), "passive_atten");
      rd(OFS_GAIN);
      chk(d, DATA_W'(pg - a_exp), "gain");
      $display("test passive done");
      wr(OFS_LOWER, 0);
      lo = 0;
      wr(OFS_CTRL, 3);
      pg = -1400;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while (d[EV_DROP_BIT] !== 1'b1 && n < 3000);
      chk({31'b0, d[EV_DROP_BIT]}, 1, "drop");
      snr_good <= 1'b0;
      pg = 200;
      repeat (260) @(posedge sys_clk);
      snr_good <= 1'b1;
      upd("after_drop");
      $display("test drop done");
      // Short batches keep the 512 failed batches inside the run time.
      snr_good <= 1'b0;
      wr(OFS_DURATION, 1);
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while (d[EV_SNR_ERR_BIT] !== 1'b1 && n < 20000);
      chk({31'b0, d[EV_SNR_ERR_BIT]}, 1, "snr_err");
      rd(OFS_BATCHES);
      chk(d, 32'h0000_0200, "batches");
      chk(DATA_W'(applied_atten_index), DATA_W'(a_exp), "abort");
      $display("test snr done");
      wrap_up();
   end
endmodule
bind loop_gain_attenuation_control lgac_chk #(
   .UPDATE_CYCLES_P(UPDATE_CYCLES_P)) u_chk (.sys_clk(sys_clk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sample(sample), .obs_snr_ok(obs_snr_ok),
   .applied_atten_index(applied_atten_index),
   .atten_update(atten_update), .irq(irq));

// ---- hw/atten_stepper.sv ----
// Computes the next attenuation index from the loop gain error.
`timescale 1ns/10ps
module atten_stepper import loop_gain_pkg::*; (
   input  wire logic [PWR_W-1:0]   target,
   input  wire logic [PWR_W-1:0]   measured,
   input  wire logic [STEP_W-1:0]  step_limit,
   input  wire logic [ATTEN_W-1:0] lower,
   input  wire logic [ATTEN_W-1:0] upper,
   input  wire logic [ATTEN_W-1:0] atten,
   output logic [ATTEN_W-1:0]      next_atten
);

   logic signed [PWR_W:0]     err;
   logic signed [PWR_W:0]     lim;
   logic signed [PWR_W+1:0]   moved;

   always_comb begin
      err = $signed({target[PWR_W-1], target})
          - $signed({measured[PWR_W-1], measured});
      lim = $signed({{(PWR_W+1-STEP_W){1'b0}}, step_limit});
      if (err > lim) begin
         err = lim;
      end else if (err < -lim) begin
         err = -lim;
      end
      // More attenuation lowers the loop gain, so a positive error
      // takes attenuation away.
      moved = $signed({{(PWR_W+2-ATTEN_W){1'b0}}, atten})
            - $signed({err[PWR_W], err});
      if (moved < $signed({{(PWR_W+2-ATTEN_W){1'b0}}, lower})) begin
         next_atten = lower;
      end else if (moved > $signed({{(PWR_W+2-ATTEN_W){1'b0}}, upper})) begin
         next_atten = upper;
      end else begin
         next_atten = moved[ATTEN_W-1:0];
      end
   end

endmodule

// ---- hw/batch_qualifier.sv ----
// Captures one timed batch, checks the power floors and divides out the loop gain.
`timescale 1ns/10ps
module batch_qualifier import loop_gain_pkg::*; (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic             start,
   input  wire batch_cfg_s       cfg,
   input  wire sample_s          sample,
   input  wire logic             snr_ok,
   output logic                  done,
   output logic                  floors_met,
   output logic                  snr_met,
   output logic [PWR_W-1:0]      gain
);

   typedef enum logic [1:0] {
      Q_IDLE = 2'b00,
      Q_RUN  = 2'b01,
      Q_EVAL = 2'b10,
      Q_DIV  = 2'b11
   } q_state_e;

   q_state_e           st_q, st_d;
   logic [CNT_W-1:0]   timer_q, timer_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   logic [SUM_W-1:0]   tx_sum_q, tx_sum_d;
   logic [SUM_W-1:0]   obs_sum_q, obs_sum_d;
   logic [SUM_W-1:0]   dvd_q, dvd_d;
   logic [SUM_W:0]     rem_q, rem_d;
   logic [5:0]         bits_q, bits_d;
   logic               neg_q, neg_d;
   logic               done_q, done_d;
   logic               floors_q, floors_d;
   logic               snr_q, snr_d;
   logic [PWR_W-1:0]   gain_q, gain_d;
   logic [SUM_W-1:0]   diff, tx_lim, obs_lim;
   logic [2*SUM_W:0]   shifted;

   always_comb begin
      st_d      = st_q;
      timer_d   = timer_q;
      cnt_d     = cnt_q;
      tx_sum_d  = tx_sum_q;
      obs_sum_d = obs_sum_q;
      dvd_d     = dvd_q;
      rem_d     = rem_q;
      bits_d    = bits_q;
      neg_d     = neg_q;
      done_d    = 1'b0;
      floors_d  = floors_q;
      snr_d     = snr_q;
      gain_d    = gain_q;
      diff      = obs_sum_q - tx_sum_q;
      tx_lim    = SUM_W'($signed(cfg.tx_power_floor) * $signed({1'b0, cnt_q}));
      obs_lim   = SUM_W'($signed(cfg.obs_power_floor) * $signed({1'b0, cnt_q}));
      shifted   = {rem_q, dvd_q} << 1;
      unique case (st_q)
         Q_IDLE: begin
            if (start) begin
               st_d      = Q_RUN;
               timer_d   = '0;
               cnt_d     = '0;
               tx_sum_d  = '0;
               obs_sum_d = '0;
            end
         end
         Q_RUN: begin
            timer_d = timer_q + 1'b1;
            if (sample.valid) begin
               cnt_d     = cnt_q + 1'b1;
               tx_sum_d  = tx_sum_q + SUM_W'($signed(sample.tx_pwr));
               obs_sum_d = obs_sum_q + SUM_W'($signed(sample.obs_pwr));
            end
            // The batch lasts exactly the programmed number of cycles.
            if (timer_q == cfg.batch_cycles - 1'b1) begin
               st_d  = Q_EVAL;
               snr_d = snr_ok;
            end
         end
         Q_EVAL: begin
            // Both paths must pass; either failure drops the whole batch.
            floors_d = (cnt_q != '0) &&
                       ($signed(tx_sum_q) >= $signed(tx_lim)) &&
                       ($signed(obs_sum_q) >= $signed(obs_lim));
            neg_d  = diff[SUM_W-1];
            dvd_d  = diff[SUM_W-1] ? SUM_W'(-diff) : diff;
            rem_d  = '0;
            bits_d = 6'(SUM_W);
            if (cnt_q == '0) begin
               st_d   = Q_IDLE;
               done_d = 1'b1;
            end else begin
               st_d = Q_DIV;
            end
         end
         Q_DIV: begin
            rem_d  = shifted[2*SUM_W:SUM_W];
            dvd_d  = shifted[SUM_W-1:0];
            if (rem_d >= {{(SUM_W+1-CNT_W){1'b0}}, cnt_q}) begin
               rem_d    = rem_d - {{(SUM_W+1-CNT_W){1'b0}}, cnt_q};
               dvd_d[0] = 1'b1;
            end
            bits_d = bits_q - 1'b1;
            if (bits_q == 6'h01) begin
               st_d   = Q_IDLE;
               done_d = 1'b1;
               gain_d = neg_q ? PWR_W'(-dvd_d) : dvd_d[PWR_W-1:0];
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q      <= Q_IDLE;
         timer_q   <= '0;
         cnt_q     <= '0;
         tx_sum_q  <= '0;
         obs_sum_q <= '0;
         dvd_q     <= '0;
         rem_q     <= '0;
         bits_q    <= '0;
         neg_q     <= 1'b0;
         done_q    <= 1'b0;
         floors_q  <= 1'b0;
         snr_q     <= 1'b0;
         gain_q    <= '0;
      end else begin
         st_q      <= st_d;
         timer_q   <= timer_d;
         cnt_q     <= cnt_d;
         tx_sum_q  <= tx_sum_d;
         obs_sum_q <= obs_sum_d;
         dvd_q     <= dvd_d;
         rem_q     <= rem_d;
         bits_q    <= bits_d;
         neg_q     <= neg_d;
         done_q    <= done_d;
         floors_q  <= floors_d;
         snr_q     <= snr_d;
         gain_q    <= gain_d;
      end
   end

   assign done       = done_q;
   assign floors_met = floors_q;
   assign snr_met    = snr_q;
   assign gain       = gain_q;

endmodule

// ---- hw/loop_gain_attenuation_control.sv ----
// Top of the closed loop gain control with its register port.
`timescale 1ns/10ps
module loop_gain_attenuation_control import loop_gain_pkg::*; #(
   parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   input  wire sample_s           sample,
   input  wire logic              obs_snr_ok,
   output logic [ATTEN_W-1:0]     applied_atten_index,
   output logic                   atten_update,
   output logic                   irq
);

   // ****************************************
   // Configuration registers
   // ****************************************
   logic               active_q, active_d;
   logic               enable_q, enable_d;
   logic [PWR_W-1:0]   tx_floor_q, tx_floor_d;
   logic [PWR_W-1:0]   obs_floor_q, obs_floor_d;
   logic [PWR_W-1:0]   target_q, target_d;
   logic [ATTEN_W-1:0] lower_q, lower_d;
   logic [ATTEN_W-1:0] upper_q, upper_d;
   logic [STEP_W-1:0]  step_q, step_d;
   logic [DUR_W-1:0]   dur_q, dur_d;
   logic [EV_W-1:0]    status_q, status_d;
   logic [EV_W-1:0]    mask_q, mask_d;
   logic [DATA_W-1:0]  rdata_q, rdata_d;
   logic [EV_W-1:0]    events;

   always_comb begin
      active_d    = active_q;
      enable_d    = enable_q;
      tx_floor_d  = tx_floor_q;
      obs_floor_d = obs_floor_q;
      target_d    = target_q;
      lower_d     = lower_q;
      upper_d     = upper_q;
      step_d      = step_q;
      dur_d       = dur_q;
      mask_d      = mask_q;
      status_d    = status_q;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CTRL: begin
               active_d = reg_wdata[CTRL_ACTIVE_BIT];
               enable_d = reg_wdata[CTRL_ENABLE_BIT];
            end
            OFS_TX_FLOOR:  tx_floor_d  = reg_wdata[PWR_W-1:0];
            OFS_OBS_FLOOR: obs_floor_d = reg_wdata[PWR_W-1:0];
            OFS_TARGET:    target_d    = reg_wdata[PWR_W-1:0];
            OFS_LOWER:     lower_d     = reg_wdata[ATTEN_W-1:0];
            OFS_UPPER:     upper_d     = reg_wdata[ATTEN_W-1:0];
            OFS_STEP:      step_d      = reg_wdata[STEP_W-1:0];
            OFS_DURATION: begin
               // Out of range durations saturate into 1 to 65536 us.
               if (reg_wdata > DATA_W'(MAX_BATCH_US)) begin
                  dur_d = DUR_W'(MAX_BATCH_US);
               end else if (reg_wdata == '0) begin
                  dur_d = DUR_W'(1);
               end else begin
                  dur_d = reg_wdata[DUR_W-1:0];
               end
            end
            OFS_STATUS:    status_d = status_q & ~reg_wdata[EV_W-1:0];
            OFS_MASK:      mask_d   = reg_wdata[EV_W-1:0];
            default: begin
            end
         endcase
      end
      // A new event wins over a clear in the same cycle.
      status_d = status_d | events;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         active_q    <= 1'b0;
         enable_q    <= 1'b0;
         tx_floor_q  <= RST_FLOOR;
         obs_floor_q <= RST_FLOOR;
         target_q    <= RST_TARGET;
         lower_q     <= RST_LOWER;
         upper_q     <= RST_UPPER;
         step_q      <= RST_STEP;
         dur_q       <= RST_DURATION;
         status_q    <= '0;
         mask_q      <= '0;
      end else begin
         active_q    <= active_d;
         enable_q    <= enable_d;
         tx_floor_q  <= tx_floor_d;
         obs_floor_q <= obs_floor_d;
         target_q    <= target_d;
         lower_q     <= lower_d;
         upper_q     <= upper_d;
         step_q      <= step_d;
         dur_q       <= dur_d;
         status_q    <= status_d;
         mask_q      <= mask_d;
      end
   end

   // ****************************************
   // Update sequencer
   // ****************************************
   typedef enum logic [1:0] {
      S_IDLE    = 2'b00,
      S_START   = 2'b01,
      S_CAPTURE = 2'b10,
      S_APPLY   = 2'b11
   } seq_state_e;

   seq_state_e         st_q, st_d;
   logic [PER_W-1:0]   period_q, period_d;
   logic [BCNT_W-1:0]  batches_q, batches_d;
   logic [ATTEN_W-1:0] atten_q, atten_d;
   logic [PWR_W-1:0]   gain_q, gain_d;
   logic               upd_q, upd_d;
   logic               tick;
   logic               q_start;
   logic               q_done;
   logic               q_floors;
   logic               q_snr;
   logic [PWR_W-1:0]   q_gain;
   logic [ATTEN_W-1:0] next_atten;
   batch_cfg_s         bcfg;

   assign tick = (period_q == PER_W'(UPDATE_CYCLES_P - 1));

   always_comb begin
      st_d      = st_q;
      period_d  = tick ? '0 : period_q + 1'b1;
      batches_d = batches_q;
      atten_d   = atten_q;
      gain_d    = gain_q;
      upd_d     = 1'b0;
      events    = '0;
      q_start   = 1'b0;
      unique case (st_q)
         S_IDLE: begin
            if (enable_q && tick) begin
               st_d      = S_START;
               batches_d = '0;
            end
         end
         S_START: begin
            q_start = 1'b1;
            st_d    = S_CAPTURE;
         end
         S_CAPTURE: begin
            if (q_done) begin
               batches_d = batches_q + 1'b1;
               if (q_floors && q_snr) begin
                  // Stop capturing; the loop gain of this batch is kept.
                  gain_d = q_gain;
                  if (active_q) begin
                     st_d = S_APPLY;
                  end else begin
                     st_d = S_IDLE;
                     events[EV_UPDATE_BIT] = 1'b1;
                  end
               end else begin
                  events[EV_DROP_BIT] = !q_floors;
                  if (batches_q == BCNT_W'(MAX_BATCHES - 1)) begin
                     st_d = S_IDLE;
                     events[EV_SNR_ERR_BIT] = 1'b1;
                  end else begin
                     st_d = S_START;
                  end
               end
            end
         end
         S_APPLY: begin
            // Only one bounded step per update; the rest waits.
            atten_d = next_atten;
            upd_d   = 1'b1;
            events[EV_UPDATE_BIT] = 1'b1;
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q      <= S_IDLE;
         period_q  <= '0;
         batches_q <= '0;
         atten_q   <= RST_ATTEN;
         gain_q    <= '0;
         upd_q     <= 1'b0;
      end else begin
         st_q      <= st_d;
         period_q  <= period_d;
         batches_q <= batches_d;
         atten_q   <= atten_d;
         gain_q    <= gain_d;
         upd_q     <= upd_d;
      end
   end

   assign bcfg.tx_power_floor  = tx_floor_q;
   assign bcfg.obs_power_floor = obs_floor_q;
   assign bcfg.batch_cycles    = CNT_W'(dur_q * CYCLES_PER_US);

   batch_qualifier u_batch (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .start      (q_start),
      .cfg        (bcfg),
      .sample     (sample),
      .snr_ok     (obs_snr_ok),
      .done       (q_done),
      .floors_met (q_floors),
      .snr_met    (q_snr),
      .gain       (q_gain)
   );

   atten_stepper u_step (
      .target     (target_q),
      .measured   (gain_q),
      .step_limit (step_q),
      .lower      (lower_q),
      .upper      (upper_q),
      .atten      (atten_q),
      .next_atten (next_atten)
   );

   // ****************************************
   // Read port and outputs
   // ****************************************
   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL: begin
               rdata_d[CTRL_ACTIVE_BIT] = active_q;
               rdata_d[CTRL_ENABLE_BIT] = enable_q;
               rdata_d[CTRL_BUSY_BIT]   = (st_q != S_IDLE);
            end
            OFS_TX_FLOOR:  rdata_d = DATA_W'(tx_floor_q);
            OFS_OBS_FLOOR: rdata_d = DATA_W'(obs_floor_q);
            OFS_TARGET:    rdata_d = DATA_W'(target_q);
            OFS_LOWER:     rdata_d = DATA_W'(lower_q);
            OFS_UPPER:     rdata_d = DATA_W'(upper_q);
            OFS_STEP:      rdata_d = DATA_W'(step_q);
            OFS_DURATION:  rdata_d = DATA_W'(dur_q);
            OFS_STATUS:    rdata_d = DATA_W'(status_q);
            OFS_MASK:      rdata_d = DATA_W'(mask_q);
            OFS_ATTEN:     rdata_d = DATA_W'(atten_q);
            OFS_GAIN:      rdata_d = DATA_W'(gain_q);
            OFS_BATCHES:   rdata_d = DATA_W'(batches_q);
            default:       rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata           = rdata_q;
   assign applied_atten_index = atten_q;
   assign atten_update        = upd_q;
   assign irq                 = |(status_q & mask_q);

endmodule

// ---- hw/loop_gain_pkg.sv ----
// Package with constants, register map and carrier types of the loop gain control.
package loop_gain_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned UPDATE_PERIOD_S = 1;
   localparam int unsigned UPDATE_CYCLES   = CLK_HZ * UPDATE_PERIOD_S;
   localparam int unsigned US_PER_S        = 1_000_000;
   localparam int unsigned CYCLES_PER_US   = CLK_HZ / US_PER_S;
   localparam int unsigned MAX_BATCH_US    = 65536;
   localparam int unsigned MAX_BATCHES     = 512;

   // ****************************************
   // Widths
   // ****************************************
   localparam int PWR_W   = 16;
   localparam int ATTEN_W = 10;
   localparam int STEP_W  = 7;
   localparam int DUR_W   = 17;
   localparam int CNT_W   = 22;
   localparam int SUM_W   = 40;
   localparam int PER_W   = 25;
   localparam int BCNT_W  = 10;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   // Attenuation table: one index is 50 millidB, top entry 41.95 dB.
   localparam int unsigned ATTEN_RES_MDB   = 50;
   localparam int unsigned ATTEN_MAX_MDB   = 41950;
   localparam logic [ATTEN_W-1:0] ATTEN_MAX_INDEX =
      ATTEN_W'(ATTEN_MAX_MDB / ATTEN_RES_MDB);

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TX_FLOOR  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OBS_FLOOR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TARGET    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_LOWER     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_UPPER     = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STEP      = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_DURATION  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_ATTEN     = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_GAIN      = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_BATCHES   = 8'h30;

   // Field positions.
   localparam int CTRL_ACTIVE_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int CTRL_BUSY_BIT   = 2;
   localparam int EV_UPDATE_BIT   = 0;
   localparam int EV_SNR_ERR_BIT  = 1;
   localparam int EV_DROP_BIT     = 2;
   localparam int EV_W            = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [PWR_W-1:0]   RST_FLOOR    = 16'hFA88;
   localparam logic [PWR_W-1:0]   RST_TARGET   = 16'h0000;
   localparam logic [ATTEN_W-1:0] RST_LOWER    = 10'h000;
   localparam logic [ATTEN_W-1:0] RST_UPPER    = ATTEN_MAX_INDEX;
   localparam logic [STEP_W-1:0]  RST_STEP     = 7'h14;
   localparam logic [DUR_W-1:0]   RST_DURATION = 17'h0_0064;
   localparam logic [ATTEN_W-1:0] RST_ATTEN    = 10'h000;

   // Power samples in signed units of 0.05 dB full scale.
   typedef struct packed {
      logic             valid;
      logic [PWR_W-1:0] tx_pwr;
      logic [PWR_W-1:0] obs_pwr;
   } sample_s;

   typedef struct packed {
      logic [PWR_W-1:0] tx_power_floor;
      logic [PWR_W-1:0] obs_power_floor;
      logic [CNT_W-1:0] batch_cycles;
   } batch_cfg_s;

endpackage
